// file: hdl/cvc_ctrl.sv
// How it works
// R1: power-on tune starts after selected delay
// R2: request high at power up skips tune
// R3: controller holds request low, then high
// R4: tune starts after high hold, noise ignored
// R5: tune_running high throughout a tune
// R6: controller waits on tune_running
// R7: controller re-tunes after warmup, temperature change
// R8: delay select picks one of two
// R9: shutdown at power up freezes delay counter
// R10: extended mode forces short delay
// R11: edge select picks strobe edge for data
// R12: config written only with sampling bit clear
// R13: dual-edge routes one input, other off
// R14: floating select enables dual-edge, short delay
// R15: extended mode picks dual-edge source channel
// R16: software clears auto phase bit first
// R17: controller drives select low before floating
// R18: leave dual-edge mode before requesting tune
// R19: full shutdown all, second shutdown one
// R20: shut channel outputs high impedance
// R21: shutdown during tune waits for finish
// R22: shutdown at power up delays tune start
// R23: request ignored while powered down
// R24: count consecutive low, high request cycles
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module cvc_ctrl
    import cvc_pkg::*;
#(
    parameter logic [31:0] DLY_SHORT = CVC_DLY_SHORT_CYC,
    parameter logic [31:0] DLY_LONG = CVC_DLY_LONG_CYC
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control pins
    input wire logic tune_req_pin,
    input wire logic delay_sel_pin,
    input wire logic delay_float_pin,
    input wire logic full_shutdown_pin,
    input wire logic second_channel_shutdown_pin,
    input wire logic output_edge_select_pin,
    // status and routing
    output logic tune_running,
    output logic strobe_rise_n,
    output logic first_out_en_n,
    output logic second_out_en_n,
    output logic dual_edge_on,
    output logic dual_edge_src_second,
    output logic second_conv_off
);

    // two-flop synchronisers for all pins
    cvc_pins_s meta_q, pins_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            pins_q <= '0;
        end
        else
        begin
            meta_q <= {tune_req_pin, delay_sel_pin, delay_float_pin, full_shutdown_pin,
                       second_channel_shutdown_pin, output_edge_select_pin};
            pins_q <= meta_q;
        end
    end

    // registers
    logic [15:0] des_q;
    logic [2:0] ctrl_q;
    logic init_q;
    logic [31:0] dly_q;
    logic [15:0] lo_cnt_q, hi_cnt_q, tune_cnt_q;
    logic armed_q;
    cvc_state_e st_q, st_d;

    // apb decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_des = paddr == CVC_DES_EN_OFS;
    wire hit_ctrl = paddr == CVC_CTRL_OFS;
    wire hit_stat = paddr == CVC_STAT_OFS;
    wire hit_time = paddr == CVC_TIME_OFS;
    wire hit_any = hit_des || hit_ctrl || hit_stat || hit_time;
    // a write that keeps the enable bit set while that register bit is already set is dropped to protect sampling clocks
    wire des_wr_ok = !des_q[CVC_DES_EN_BIT] || !pwdata[CVC_DES_EN_BIT]; // R12

    wire ext_mode = ctrl_q[CVC_CTRL_EXT_BIT];
    wire sw_req = wr && hit_ctrl && pwdata[CVC_CTRL_REQ_BIT];
    wire powered_down = pins_q.full_shutdown;

    // dual-edge: pin float in basic mode, register bit in extended mode
    wire des_on = ext_mode ? des_q[CVC_DES_EN_BIT] : pins_q.delay_float; // R14
    wire des_src = ext_mode && des_q[CVC_DES_SRC_BIT]; // R15

    // delay length choice
    wire use_short = ext_mode || pins_q.delay_float || !pins_q.delay_sel; // R8 R10 R14
    wire [31:0] dly_target = use_short ? DLY_SHORT : DLY_LONG;

    // request qualification on the synchronised pin
    wire lo_done = lo_cnt_q >= CVC_HOLD_LO_CYC; // R24
    wire hi_done = hi_cnt_q == CVC_HOLD_HI_CYC - 16'h0001; // R4
    wire pin_fire = pins_q.tune_req && armed_q && hi_done && !powered_down; // R23
    wire tune_done = tune_cnt_q == CVC_TUNE_CYC - 16'h0001;

    // sequencer next state
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            CVC_ST_DELAY:
                if (!powered_down && dly_q >= dly_target - 32'h1) // R1 R22
                    st_d = init_q ? CVC_ST_IDLE : CVC_ST_TUNE; // R2
            CVC_ST_IDLE:
                if (powered_down)
                    st_d = CVC_ST_DOWN;
                else if (pin_fire || sw_req) // R4
                    st_d = CVC_ST_TUNE;
            CVC_ST_TUNE:
                if (tune_done) // R21
                    st_d = powered_down ? CVC_ST_DOWN : CVC_ST_IDLE;
            CVC_ST_DOWN:
                if (!powered_down)
                    st_d = CVC_ST_IDLE;
            default:
                st_d = CVC_ST_DELAY;
        endcase
    end

    // state, delay and tune counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= CVC_ST_DELAY;
            dly_q <= '0;
            tune_cnt_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            if (st_q == CVC_ST_DELAY && !powered_down) // R9
                dly_q <= dly_q + 32'h1;
            tune_cnt_q <= (st_q == CVC_ST_TUNE) ? tune_cnt_q + 16'h1 : 16'h0;
        end
    end

    // sample the request level once the synchroniser has filled; the raw pin
    // is left to the synchroniser alone, so a metastable level cannot reach init_q
    logic [1:0] wake_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_q <= 2'h0;
            init_q <= 1'b0;
        end
        else
        begin
            if (wake_q != 2'h3)
                wake_q <= wake_q + 2'h1;
            // two edges fill the synchroniser, the third reads its output
            if (wake_q == 2'h2)
                init_q <= pins_q.tune_req; // R2
        end
    end

    // low then high run counters; low run arms the high run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lo_cnt_q <= '0;
            hi_cnt_q <= '0;
            armed_q <= 1'b0;
        end
        else if (powered_down)
        begin
            lo_cnt_q <= '0; // R23
            hi_cnt_q <= '0;
            armed_q <= 1'b0;
        end
        else if (!pins_q.tune_req)
        begin
            hi_cnt_q <= '0;
            if (!lo_done)
                lo_cnt_q <= lo_cnt_q + 16'h1; // R24
            armed_q <= lo_done || armed_q;
        end
        else
        begin
            lo_cnt_q <= '0;
            if (!hi_done)
                hi_cnt_q <= hi_cnt_q + 16'h1;
            if (pin_fire)
                armed_q <= 1'b0;
        end
    end

    // register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            des_q <= CVC_DES_EN_RST;
            ctrl_q <= CVC_CTRL_RST;
        end
        else if (wr && hit_des && des_wr_ok)
            des_q <= pwdata[15:0];
        else if (wr && hit_ctrl)
            ctrl_q <= {1'b0, pwdata[1:0]};
    end

    // read mux
    wire [31:0] stat_word = {25'h0, des_src, des_on, powered_down,
                             pins_q.second_channel_shutdown, armed_q, init_q, st_q == CVC_ST_TUNE};
    wire [31:0] rd_word = hit_des ? {16'h0, des_q} :
                          hit_ctrl ? {29'h0, ctrl_q} :
                          hit_stat ? stat_word :
                          hit_time ? dly_q : 32'h0;

    // zero-wait answer: pready on the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            prdata <= (psel && !penable && !pwrite) ? rd_word : 32'h0;
        end
    end

    // edge select: pin in basic mode, register in extended mode
    wire edge_rise = ext_mode ? ctrl_q[CVC_CTRL_EDGE_BIT] : pins_q.output_edge_select; // R11

    // tune flag and dual-edge routing, registered so the pins never glitch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tune_running <= 1'b0;
            strobe_rise_n <= 1'b0;
            dual_edge_on <= 1'b0;
            dual_edge_src_second <= 1'b0;
            second_conv_off <= 1'b0;
        end
        else
        begin
            // from st_d so the flag rises with the state, not a cycle behind
            tune_running <= st_d == CVC_ST_TUNE; // R5
            strobe_rise_n <= !edge_rise; // R11
            dual_edge_on <= des_on; // R13
            dual_edge_src_second <= des_src; // R15
            second_conv_off <= pins_q.second_channel_shutdown || des_on; // R13 R19
        end
    end

    // channel output enables; a woken channel still carries stale pipeline data to flush
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_out_en_n <= 1'b1;
            second_out_en_n <= 1'b1;
        end
        else
        begin
            first_out_en_n <= powered_down; // R19 R20
            second_out_en_n <= powered_down || pins_q.second_channel_shutdown; // R19 R20
        end
    end

    // checks
    tune_len_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
        $rose(tune_running) |-> tune_running[*8]) else $error("tune too short");
    no_down_start_a: assert property (@(posedge pclk) disable iff (!presetn) // R23
        (st_q == CVC_ST_IDLE && powered_down) |=> st_q != CVC_ST_TUNE) else $error("tune began powered down");
    delay_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (st_q == CVC_ST_DELAY && powered_down) |=> dly_q == $past(dly_q)) else $error("delay ran in shutdown");
    finish_first_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
        (st_q == CVC_ST_TUNE && !tune_done) |=> st_q == CVC_ST_TUNE) else $error("tune cut short");
    out_hiz_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
        powered_down |=> first_out_en_n && second_out_en_n) else $error("outputs driven in shutdown");
    short_ext_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        ext_mode |-> dly_target == DLY_SHORT) else $error("long delay in extended mode");
    des_guard_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (wr && hit_des && des_q[CVC_DES_EN_BIT] && pwdata[CVC_DES_EN_BIT]) |=> $stable(des_q))
        else $error("config write with dual-edge on");
    pin_start_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
        (st_q == CVC_ST_IDLE && pin_fire) |=> tune_running) else $error("qualified request missed");
    edge_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (!ext_mode && $stable(ext_mode)) |=> strobe_rise_n == !$past(pins_q.output_edge_select))
        else $error("edge select wrong");
    apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready) else $error("apb answer late");

    // power-on and request checks, all but the disarm check seen from the running flag
    run_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
        tune_running == (st_q == CVC_ST_TUNE))
        else $error("running flag out of step");
    skip_init_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
        ($rose(tune_running) && $past(st_q) == CVC_ST_DELAY) |-> !init_q)
        else $error("power-on tune not skipped");
    delay_len_a: assert property (@(posedge pclk) disable iff (!presetn) // R1 R8
        ($rose(tune_running) && $past(st_q) == CVC_ST_DELAY) |-> dly_q >= $past(dly_target))
        else $error("power-on tune too early");
    cmd_only_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
        ($rose(tune_running) && $past(st_q) == CVC_ST_IDLE) |-> ($past(pin_fire) || $past(sw_req)))
        else $error("tune began without a request");
    down_disarm_a: assert property (@(posedge pclk) disable iff (!presetn) // R23
        powered_down |=> !armed_q)
        else $error("request armed in shutdown");

    // channel shutdown checks
    second_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
        pins_q.second_channel_shutdown |=>
            second_conv_off && second_out_en_n && (first_out_en_n == $past(powered_down)))
        else $error("second channel shutdown wrong");

    // scenarios worth seeing
    tune_seen_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(tune_running));
    down_mid_c: cover property (@(posedge pclk) disable iff (!presetn) tune_running && powered_down);
    des_on_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(dual_edge_on));
    pin_fire_c: cover property (@(posedge pclk) disable iff (!presetn) st_q == CVC_ST_IDLE && pin_fire);
    sw_req_c: cover property (@(posedge pclk) disable iff (!presetn) st_q == CVC_ST_IDLE && sw_req);

endmodule
`default_nettype wire

// file: hdl/cvc_pkg.sv
package cvc_pkg;

    // register map, byte addresses
    localparam logic [11:0] CVC_DES_EN_OFS = 12'h034;    // dual_edge_sampling_enable, word 0xd
    localparam logic [11:0] CVC_CTRL_OFS = 12'h000;
    localparam logic [11:0] CVC_STAT_OFS = 12'h004;
    localparam logic [11:0] CVC_TIME_OFS = 12'h008;

    // index of the dual_edge_sampling_enable register
    localparam logic [3:0] CVC_DES_EN_IDX = 4'hd;

    // dual_edge_sampling_enable fields
    localparam int CVC_DES_EN_BIT = 15;
    localparam int CVC_DES_SRC_BIT = 13;
    localparam int CVC_AUTO_PHASE_BIT = 14;
    localparam logic [15:0] CVC_DES_EN_RST = 16'h0000;

    // ctrl fields
    localparam int CVC_CTRL_EXT_BIT = 0;
    localparam int CVC_CTRL_EDGE_BIT = 1;
    localparam int CVC_CTRL_REQ_BIT = 2;
    localparam logic [2:0] CVC_CTRL_RST = 3'h2;

    // qualification and delay counts, in clock cycles
    localparam logic [15:0] CVC_HOLD_LO_CYC = 16'h0050;
    localparam logic [15:0] CVC_HOLD_HI_CYC = 16'h0050;
    localparam logic [15:0] CVC_TUNE_CYC = 16'h0400;
    localparam logic [31:0] CVC_DLY_SHORT_CYC = 32'h0000_1000;
    localparam logic [31:0] CVC_DLY_LONG_CYC = 32'h0004_0000;

    // sequencer states
    typedef enum logic [2:0]
    {
        CVC_ST_DELAY = 3'b000,
        CVC_ST_IDLE = 3'b001,
        CVC_ST_TUNE = 3'b010,
        CVC_ST_DOWN = 3'b011
    } cvc_state_e;

    // synchronised control pins
    typedef struct packed
    {
        logic tune_req;
        logic delay_sel;
        logic delay_float;
        logic full_shutdown;
        logic second_channel_shutdown;
        logic output_edge_select;
    } cvc_pins_s;

endpackage

// file: sim/cvc_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cvc_ctrl_tb_top
    import cvc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic er;
    cvc_pins_s pins;
    logic tune_running;
    logic strobe_rise_n;
    logic first_out_en_n;
    logic second_out_en_n;
    logic dual_edge_on;
    logic dual_edge_src_second;
    logic second_conv_off;
    int bad_count = 0;
    int tests_run = 0;

    // 125 MHz clock
    always #4 pclk = ~pclk;

    // short delay counts keep the power-on waits brief
    cvc_ctrl #(.DLY_SHORT(32'h0000_0010), .DLY_LONG(32'h0000_0040)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tune_req_pin(pins.tune_req), .delay_sel_pin(pins.delay_sel),
        .delay_float_pin(pins.delay_float), .full_shutdown_pin(pins.full_shutdown),
        .second_channel_shutdown_pin(pins.second_channel_shutdown),
        .output_edge_select_pin(pins.output_edge_select), .tune_running(tune_running),
        .strobe_rise_n(strobe_rise_n), .first_out_en_n(first_out_en_n),
        .second_out_en_n(second_out_en_n), .dual_edge_on(dual_edge_on),
        .dual_edge_src_second(dual_edge_src_second), .second_conv_off(second_conv_off));

    cvc_far_end far (.pclk(pclk), .tune_running(tune_running), .pins(pins));

    task automatic final_report;
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            bad_count++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // power-on with the given pin levels
    task automatic rst(input logic sel, input logic flt, input logic req, input logic pd);
        presetn <= 1'b0;
        far.pins <= '{tune_req: req, delay_sel: sel, delay_float: flt, full_shutdown: pd, default: 1'b0};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // bounded watch of the running flag; reports whether a tune showed up
    task automatic wait_tune(input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < n && !seen; i++)
        begin
            @(posedge pclk);
            seen = (tune_running === 1'b1);
        end
        `CHK(seen, exp);
        if (exp && !seen)
            final_report();
    endtask

    // length of the running tune must sit in the window
    task automatic tune_len(input int lo, input int hi);
        int n;
        n = 0;
        while (tune_running === 1'b1 && n < 1200)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK((n >= lo && n <= hi), 1'b1);
        if (n >= 1200)
            final_report();
    endtask

    initial
    begin
        // long delay selected; register reset values and an unmapped read first
        rst(1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge pclk);
        apb(1'b0, CVC_CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0000_0002);
        apb(1'b0, CVC_DES_EN_OFS, 32'h0);
        `CHK(rd, {16'h0000, CVC_DES_EN_RST});
        apb(1'b0, 12'h010, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0});
        wait_tune(40, 1'b0);
        wait_tune(40, 1'b1);
        tune_len(1000, 1030);
        // short pulse is noise, a full one starts a tune
        far.request(100, 40);
        wait_tune(200, 1'b0);
        far.request(100, 90);
        wait_tune(20, 1'b1);
        // shutdown mid-tune waits for the finish, then outputs float
        far.pins.full_shutdown <= 1'b1;
        tune_len(990, 1030);
        repeat (3) @(posedge pclk);
        `CHK({first_out_en_n, second_out_en_n}, 2'b11);
        far.request(100, 90);
        wait_tune(300, 1'b0);
        far.pins.full_shutdown <= 1'b0;
        wait_tune(300, 1'b0);
        `CHK({first_out_en_n, second_out_en_n}, 2'b00);
        far.pins.second_channel_shutdown <= 1'b1;
        repeat (5) @(posedge pclk);
        `CHK({first_out_en_n, second_out_en_n, second_conv_off}, 3'b011);
        far.pins.second_channel_shutdown <= 1'b0;
        for (int v = 0; v < 2; v++)
        begin
            far.pins.output_edge_select <= v[0];
            repeat (5) @(posedge pclk);
            `CHK(strobe_rise_n, ~v[0]);
        end
        // short delay, skipped tune, shutdown held at power up
        rst(1'b0, 1'b0, 1'b0, 1'b0);
        wait_tune(40, 1'b1);
        rst(1'b1, 1'b0, 1'b1, 1'b0);
        wait_tune(200, 1'b0);
        rst(1'b1, 1'b0, 1'b0, 1'b1);
        wait_tune(200, 1'b0);
        far.pins.full_shutdown <= 1'b0;
        wait_tune(100, 1'b1);
        // floating select: dual-edge on the first channel with the short delay
        rst(1'b0, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge pclk);
        far.pins <= '{delay_sel: 1'b1, delay_float: 1'b1, default: 1'b0};
        wait_tune(40, 1'b1);
        `CHK({dual_edge_on, second_conv_off}, 2'b11);
        // extended mode ignores the select; config written with dual-edge clear
        rst(1'b1, 1'b0, 1'b0, 1'b0);
        @(posedge pclk);
        apb(1'b1, CVC_CTRL_OFS, 32'h0000_0001);
        wait_tune(40, 1'b1);
        `CHK(strobe_rise_n, 1'b1);
        tune_len(990, 1030);
        apb(1'b1, CVC_CTRL_OFS, 32'h0000_0005);
        wait_tune(10, 1'b1);
        apb(1'b0, CVC_STAT_OFS, 32'h0);
        `CHK(rd, 32'h0000_0005);
        apb(1'b0, CVC_TIME_OFS, 32'h0);
        `CHK(rd, 32'h0000_0010);
        apb(1'b1, CVC_DES_EN_OFS, 32'h0000_2000);
        apb(1'b1, CVC_DES_EN_OFS, 32'h0000_a000);
        apb(1'b0, CVC_DES_EN_OFS, 32'h0);
        `CHK(rd, 32'h0000_a000);
        repeat (3) @(posedge pclk);
        `CHK({dual_edge_on, dual_edge_src_second}, 2'b11);
        apb(1'b1, CVC_DES_EN_OFS, 32'h0000_8000);
        apb(1'b0, CVC_DES_EN_OFS, 32'h0);
        `CHK(rd, 32'h0000_a000);
        final_report();
    end
endmodule
`default_nettype wire

// file: sim/cvc_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module cvc_far_end
    import cvc_pkg::*;
(
    // clock and status from the converter
    input wire logic pclk,
    input wire logic tune_running,
    // control pins toward the converter
    output var cvc_pins_s pins
);
    // all pins low from power up, so the select pin is low before any float
    initial pins = '0;
    // request: low hold arms, high hold qualifies, then back low
    // the bench only calls this with dual-edge off, and later calls stand in for re-tunes
    task automatic request(input int lo, input int hi);
        pins.tune_req <= 1'b0;
        repeat (lo) @(posedge pclk);
        pins.tune_req <= 1'b1;
        repeat (hi) @(posedge pclk);
        pins.tune_req <= 1'b0;
    endtask
endmodule
`default_nettype wire
